// ===== core/mux_ctl_pkg.sv
// shared constants for the serial mux switch controller and its bus master
package mux_ctl_pkg;
  localparam int          SW_W            = 8;
  localparam int          RB_W            = 16;
  localparam logic [3:0]  ADDR_FIXED      = 4'ha;
  // second data byte fields
  localparam int          COMMIT_POS      = 1;
  localparam int          SOFT_RST_N_POS  = 0;
  // command byte
  localparam int          CMD_VALUE_POS   = 7;
  localparam logic [6:0]  SEL_ALL_A       = 7'h00;
  localparam logic [6:0]  SEL_ALL_B       = 7'h01;
  localparam logic [6:0]  SEL_SINGLE_LO   = 7'h02;
  localparam logic [6:0]  SEL_SINGLE_HI   = 7'h09;
  localparam logic [6:0]  SEL_DIS_LO      = 7'h0e;
  localparam logic [6:0]  SEL_DIS_HI      = 7'h11;
  localparam logic [6:0]  SEL_GPO         = 7'h14;
  localparam logic [6:0]  SEL_DIS_ALL     = 7'h1f;
  localparam logic [7:0]  MASK_A          = 8'haa;
  localparam logic [7:0]  MASK_B          = 8'h55;
  // readback layout
  localparam int          RB_SW_LSB       = 8;
  localparam int          RB_GPO_POS      = 3;
  localparam logic [15:0] RB_RESET        = 16'h0000;
  // master register map
  localparam logic [3:0]  HOST_CMD_OFS    = 4'h0;
  localparam logic [3:0]  HOST_STAT_OFS   = 4'h4;
  localparam logic [3:0]  HOST_RDATA_OFS  = 4'h8;
  localparam int          CMD_RD_POS      = 16;
  localparam int          CMD_ASEL_LSB    = 20;
  localparam int          STAT_BUSY_POS   = 0;
  localparam int          STAT_NACK_POS   = 1;
  // link timing
  localparam int          CLK_PERIOD_PS   = 5000;
  localparam int          SCL_QTR_NS      = 2500;
  localparam int          SCL_QTR_CYC     = (SCL_QTR_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
endpackage

// ===== core/mux_link_if.sv
// two-wire link between the bus master and the mux switch slave
`timescale 1ns/1ps
interface mux_link_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;

  // open drain with pull-up
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

  modport device (
    input  scl,
    input  sda,
    output dev_sda_o,
    output dev_sda_oe
  );
  modport host (
    output scl,
    output host_sda_o,
    output host_sda_oe,
    input  sda
  );
endinterface

// ===== core/mux_switch_slave.sv
// serial slave: address match, write decode, staged commit, status readback
`timescale 1ns/1ps
module mux_switch_slave #(
  parameter bit HAS_GPO = 1'b1
) (
  input  wire logic                          i_clk,
  input  wire logic                          i_rst_n,
  input  wire logic [2:0]                    i_address_select,
  output logic      [mux_ctl_pkg::SW_W-1:0]  o_switch,
  output logic                               o_general_output,
  mux_link_if.device                         link
);
  import mux_ctl_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE     = 3'b000,
    S_ADDR     = 3'b001,
    S_ADDR_ACK = 3'b010,
    S_WR       = 3'b011,
    S_WR_ACK   = 3'b100,
    S_RD       = 3'b101,
    S_RD_ACK   = 3'b110
  } slv_state_e;

  slv_state_e        state_ff;
  logic              scl_meta_ff;
  logic              scl_ff;
  logic              scl_prev_ff;
  logic              sda_meta_ff;
  logic              sda_ff;
  logic              sda_prev_ff;
  logic [2:0]        asel_meta_ff;
  logic [2:0]        asel_ff;
  logic [2:0]        cnt_ff;
  logic              byte_done_ff;
  logic              rd_ff;
  logic              second_ff;
  logic [7:0]        shreg_ff;
  logic [7:0]        cmd_ff;
  logic [7:0]        ctl_ff;
  logic              word_pulse_ff;
  logic              sda_oe_ff;
  logic [RB_W-1:0]   tx_ff;
  logic [SW_W-1:0]   stage_ff;
  logic              gpo_stage_ff;
  logic [SW_W-1:0]   nxt_stage;
  logic              nxt_gpo_stage;
  logic [RB_W-1:0]   readback;
  logic              scl_rise;
  logic              scl_fall;
  logic              start_det;
  logic              stop_det;
  logic [6:0]        sel;
  logic              val;
  logic [2:0]        single_idx;
  logic [1:0]        dis_idx;

  // pins pass two flops; edges are found only on the second stage
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      scl_meta_ff  <= 1'b1;
      scl_ff       <= 1'b1;
      scl_prev_ff  <= 1'b1;
      sda_meta_ff  <= 1'b1;
      sda_ff       <= 1'b1;
      sda_prev_ff  <= 1'b1;
      asel_meta_ff <= 3'h0;
      asel_ff      <= 3'h0;
    end else begin
      scl_meta_ff  <= link.scl;
      scl_ff       <= scl_meta_ff;
      scl_prev_ff  <= scl_ff;
      sda_meta_ff  <= link.sda;
      sda_ff       <= sda_meta_ff;
      sda_prev_ff  <= sda_ff;
      asel_meta_ff <= i_address_select;
      asel_ff      <= asel_meta_ff;
    end
  end

  assign scl_rise  = scl_ff & ~scl_prev_ff;
  assign scl_fall  = ~scl_ff & scl_prev_ff;
  assign start_det = scl_ff & scl_prev_ff & sda_prev_ff & ~sda_ff;
  assign stop_det  = scl_ff & scl_prev_ff & ~sda_prev_ff & sda_ff;

  assign readback = {o_switch, 4'h0,
                     o_general_output & HAS_GPO, 3'h0};

  // sda is only ever pulled low; scl is never driven
  assign link.dev_sda_o  = 1'b0;
  assign link.dev_sda_oe = sda_oe_ff;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff      <= S_IDLE;
      cnt_ff        <= 3'h0;
      byte_done_ff  <= 1'b0;
      rd_ff         <= 1'b0;
      second_ff     <= 1'b0;
      shreg_ff      <= 8'h00;
      cmd_ff        <= 8'h00;
      ctl_ff        <= 8'h00;
      word_pulse_ff <= 1'b0;
      sda_oe_ff     <= 1'b0;
      tx_ff         <= RB_RESET;
    end else begin
      word_pulse_ff <= 1'b0;
      if (start_det) begin
        state_ff     <= S_ADDR;
        cnt_ff       <= 3'h0;
        byte_done_ff <= 1'b0;
        sda_oe_ff    <= 1'b0;
      end else if (stop_det) begin
        state_ff  <= S_IDLE;
        sda_oe_ff <= 1'b0;
      end else if (scl_rise) begin
        case (state_ff)
          S_ADDR, S_WR: begin
            shreg_ff     <= {shreg_ff[6:0], sda_ff};
            cnt_ff       <= cnt_ff + 3'h1;
            byte_done_ff <= (cnt_ff == 3'h7);
          end
          S_RD: begin
            cnt_ff       <= cnt_ff + 3'h1;
            byte_done_ff <= (cnt_ff == 3'h7);
          end
          S_RD_ACK: begin
            // no acknowledge from the master ends the read
            if (sda_ff) begin
              state_ff <= S_IDLE;
            end
          end
          default: begin
          end
        endcase
      end else if (scl_fall) begin
        case (state_ff)
          S_ADDR: begin
            if (byte_done_ff) begin
              byte_done_ff <= 1'b0;
              if (shreg_ff[7:1] == {ADDR_FIXED, asel_ff}) begin
                sda_oe_ff <= 1'b1;
                rd_ff     <= shreg_ff[0];
                state_ff  <= S_ADDR_ACK;
              end else begin
                state_ff <= S_IDLE;
              end
            end
          end
          S_ADDR_ACK: begin
            cnt_ff    <= 3'h0;
            second_ff <= 1'b0;
            if (rd_ff) begin
              tx_ff     <= readback;
              sda_oe_ff <= ~readback[RB_W-1];
              state_ff  <= S_RD;
            end else begin
              sda_oe_ff <= 1'b0;
              state_ff  <= S_WR;
            end
          end
          S_WR: begin
            if (byte_done_ff) begin
              byte_done_ff <= 1'b0;
              sda_oe_ff    <= 1'b1;
              state_ff     <= S_WR_ACK;
              second_ff    <= ~second_ff;
              if (!second_ff) begin
                cmd_ff <= shreg_ff;
              end else begin
                ctl_ff        <= shreg_ff;
                word_pulse_ff <= 1'b1;
              end
            end
          end
          S_WR_ACK: begin
            sda_oe_ff <= 1'b0;
            state_ff  <= S_WR;
          end
          S_RD: begin
            if (byte_done_ff) begin
              byte_done_ff <= 1'b0;
              sda_oe_ff    <= 1'b0;
              state_ff     <= S_RD_ACK;
            end else begin
              sda_oe_ff <= ~tx_ff[RB_W-2];
              tx_ff     <= {tx_ff[RB_W-2:0], 1'b0};
            end
          end
          S_RD_ACK: begin
            sda_oe_ff <= ~tx_ff[RB_W-2];
            tx_ff     <= {tx_ff[RB_W-2:0], 1'b0};
            state_ff  <= S_RD;
          end
          default: begin
            sda_oe_ff <= 1'b0;
          end
        endcase
      end
    end
  end

  // a staged copy keeps only the latest command per element
  always_comb begin
    nxt_stage     = stage_ff;
    nxt_gpo_stage = gpo_stage_ff;
    sel           = cmd_ff[6:0];
    val           = cmd_ff[CMD_VALUE_POS];
    single_idx    = 3'(sel - SEL_SINGLE_LO);
    dis_idx       = 2'(sel - SEL_DIS_LO);
    if (sel == SEL_ALL_A) begin
      nxt_stage = (stage_ff & ~MASK_A) | (val ? MASK_A : 8'h00);
    end else if (sel == SEL_ALL_B) begin
      nxt_stage = (stage_ff & ~MASK_B) | (val ? MASK_B : 8'h00);
    end else if (sel >= SEL_SINGLE_LO && sel <= SEL_SINGLE_HI) begin
      nxt_stage[3'h7 - single_idx] = val;
    end else if (sel >= SEL_DIS_LO && sel <= SEL_DIS_HI) begin
      nxt_stage[{~dis_idx, 1'b1}] = 1'b0;
      nxt_stage[{~dis_idx, 1'b0}] = 1'b0;
    end else if (sel == SEL_DIS_ALL && !val) begin
      nxt_stage = 8'h00;
    end else if (sel == SEL_GPO && HAS_GPO) begin
      nxt_gpo_stage = val;
    end
    // any other code falls through untouched
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stage_ff         <= 8'h00;
      gpo_stage_ff     <= 1'b0;
      o_switch         <= 8'h00;
      o_general_output <= 1'b0;
    end else if (word_pulse_ff) begin
      if (!ctl_ff[SOFT_RST_N_POS]) begin
        stage_ff         <= 8'h00;
        gpo_stage_ff     <= 1'b0;
        o_switch         <= 8'h00;
        o_general_output <= 1'b0;
      end else begin
        stage_ff     <= nxt_stage;
        gpo_stage_ff <= nxt_gpo_stage;
        if (ctl_ff[COMMIT_POS]) begin
          o_switch         <= nxt_stage;
          o_general_output <= nxt_gpo_stage;
        end
      end
    end
  end
endmodule

// ===== core/mux_switch_master.sv
// bus master for the mux switch slave, driven from AHB-Lite registers
`timescale 1ns/1ps
module mux_switch_master #(
  parameter int QTR_CYC = mux_ctl_pkg::SCL_QTR_CYC
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  mux_link_if.host         link
);
  import mux_ctl_pkg::*;

  typedef enum logic [1:0] {
    H_IDLE  = 2'b00,
    H_START = 2'b01,
    H_BIT   = 2'b10,
    H_STOP  = 2'b11
  } host_state_e;

  host_state_e   state_ff;
  logic [15:0]   div_ff;
  logic [1:0]    phase_ff;
  logic [1:0]    byte_ff;
  logic [3:0]    bit_ff;
  logic          scl_ff;
  logic          oe_ff;
  logic          nack_ff;
  logic          sda_meta_ff;
  logic          sda_ff;
  logic          wr_pend_ff;
  logic [3:0]    addr_ff;
  logic [15:0]   word_ff;
  logic          rd_ff;
  logic [2:0]    asel_ff;
  logic [15:0]   rx_ff;
  logic [15:0]   rdata_ff;
  logic          tick;
  logic          is_wbyte;
  logic [7:0]    tx_byte;
  logic          busy;
  logic          take;
  logic          cmd_wr;

  assign link.scl        = scl_ff;
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe = oe_ff;
  assign tick     = (div_ff == 16'(QTR_CYC - 1));
  assign is_wbyte = (byte_ff == 2'h0) | ~rd_ff;
  assign tx_byte  = (byte_ff == 2'h0) ? {ADDR_FIXED, asel_ff, rd_ff} :
                    (byte_ff == 2'h1) ? word_ff[15:8] : word_ff[7:0];
  assign busy     = (state_ff != H_IDLE);
  assign take     = i_hsel & i_hready & i_htrans[1];
  assign cmd_wr   = wr_pend_ff & (addr_ff == HOST_CMD_OFS) & ~busy;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sda_meta_ff <= 1'b1;
      sda_ff      <= 1'b1;
    end else begin
      sda_meta_ff <= link.sda;
      sda_ff      <= sda_meta_ff;
    end
  end

  // zero-wait slave; read data loaded in the address phase
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_pend_ff  <= 1'b0;
      addr_ff     <= 4'h0;
      o_hrdata    <= 32'h0;
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end else begin
      wr_pend_ff <= take & i_hwrite;
      if (take) begin
        addr_ff <= i_haddr[3:0];
      end
      if (take && !i_hwrite) begin
        case (i_haddr[3:0])
          HOST_STAT_OFS: o_hrdata <= {30'h0, nack_ff, busy | cmd_wr};
          HOST_RDATA_OFS: o_hrdata <= {16'h0, rdata_ff};
          default: o_hrdata <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= H_IDLE;
      div_ff   <= 16'h0;
      phase_ff <= 2'h0;
      byte_ff  <= 2'h0;
      bit_ff   <= 4'h0;
      scl_ff   <= 1'b1;
      oe_ff    <= 1'b0;
      nack_ff  <= 1'b0;
      word_ff  <= 16'h0;
      rd_ff    <= 1'b0;
      asel_ff  <= 3'h0;
      rx_ff    <= 16'h0;
      rdata_ff <= 16'h0;
    end else if (state_ff == H_IDLE) begin
      div_ff   <= 16'h0;
      phase_ff <= 2'h0;
      // writes to the command register while busy are dropped
      if (cmd_wr) begin
        word_ff  <= i_hwdata[15:0];
        rd_ff    <= i_hwdata[CMD_RD_POS];
        asel_ff  <= i_hwdata[CMD_ASEL_LSB +: 3];
        nack_ff  <= 1'b0;
        byte_ff  <= 2'h0;
        bit_ff   <= 4'h0;
        state_ff <= H_START;
      end
    end else begin
      div_ff <= tick ? 16'h0 : div_ff + 16'h1;
      if (tick) begin
        phase_ff <= phase_ff + 2'h1;
        case (state_ff)
          H_START: begin
            if (phase_ff == 2'h2) begin
              oe_ff <= 1'b1;
            end
            if (phase_ff == 2'h3) begin
              scl_ff   <= 1'b0;
              state_ff <= H_BIT;
            end
          end
          H_BIT: begin
            case (phase_ff)
              2'h0: begin
                if (bit_ff < 4'h8) begin
                  oe_ff <= is_wbyte & ~tx_byte[3'h7 - bit_ff[2:0]];
                end else begin
                  // acknowledge the first read byte, not the last
                  oe_ff <= ~is_wbyte & (byte_ff != 2'h2);
                end
              end
              2'h1: scl_ff <= 1'b1;
              2'h2: begin
                if (bit_ff < 4'h8 && !is_wbyte) begin
                  rx_ff <= {rx_ff[14:0], sda_ff};
                end
                if (bit_ff == 4'h8 && is_wbyte && sda_ff) begin
                  nack_ff <= 1'b1;
                end
              end
              default: begin
                scl_ff <= 1'b0;
                if (bit_ff == 4'h8) begin
                  bit_ff  <= 4'h0;
                  byte_ff <= byte_ff + 2'h1;
                  if (byte_ff == 2'h2 || nack_ff) begin
                    state_ff <= H_STOP;
                  end
                end else begin
                  bit_ff <= bit_ff + 4'h1;
                end
              end
            endcase
          end
          default: begin
            if (phase_ff == 2'h0) begin
              oe_ff <= 1'b1;
            end
            if (phase_ff == 2'h1) begin
              scl_ff <= 1'b1;
            end
            if (phase_ff == 2'h2) begin
              oe_ff <= 1'b0;
            end
            if (phase_ff == 2'h3) begin
              state_ff <= H_IDLE;
              if (rd_ff && !nack_ff) begin
                rdata_ff <= rx_ff;
              end
            end
          end
        endcase
      end
    end
  end
endmodule

// ===== dv/mux_link_asserts.sv
// protocol checks on the two-wire link between the mux master and slave
`timescale 1ns/1ps
module mux_link_asserts (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic scl,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic sda
);
  logic       scl_ff;
  logic       sda_ff;
  logic [4:0] bit_cnt_ff;
  logic [7:0] addr_ff;
  logic       acked_ff;
  logic       rise;
  logic       start;
  logic       stop;
  logic       rd_dir;

  assign rise   = scl & ~scl_ff;
  assign start  = scl & scl_ff & sda_ff & ~sda;
  assign stop   = scl & scl_ff & ~sda_ff & sda;
  assign rd_dir = addr_ff[0] & acked_ff;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      scl_ff <= 1'b1;
      sda_ff <= 1'b1;
    end else begin
      scl_ff <= scl;
      sda_ff <= sda;
    end
  end

  // bit_cnt counts scl rises since the last start; 8 means the address ack slot
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bit_cnt_ff <= 5'h0;
    end else if (start) begin
      bit_cnt_ff <= 5'h0;
    end else if (rise && bit_cnt_ff != 5'h1f) begin
      bit_cnt_ff <= bit_cnt_ff + 5'h1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      addr_ff <= 8'h0;
    end else if (rise && bit_cnt_ff < 5'h8) begin
      addr_ff <= {addr_ff[6:0], sda};
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acked_ff <= 1'b0;
    end else if (start) begin
      acked_ff <= 1'b0;
    end else if (rise && bit_cnt_ff == 5'h8) begin
      acked_ff <= dev_sda_oe;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_dev_pull_only: assert property (dev_sda_o == 1'b0)
    else $error("slave drives sda high");
  a_dev_steady_high: assert property (scl && scl_ff |-> $stable(dev_sda_oe))
    else $error("slave sda moved while scl high");
  a_addr_no_drive: assert property (rise && bit_cnt_ff < 5'h8 |-> !dev_sda_oe)
    else $error("slave drove during address bits");
  a_ack_fixed_upper: assert property (
    rise && bit_cnt_ff == 5'h8 && dev_sda_oe |-> addr_ff[7:4] == mux_ctl_pkg::ADDR_FIXED)
    else $error("slave acked a foreign address");
  a_write_data_ack: assert property (
    rise && !addr_ff[0] && acked_ff && (bit_cnt_ff == 5'd17 || bit_cnt_ff == 5'd26)
    |-> dev_sda_oe)
    else $error("write byte not acknowledged");
  a_host_frees_ack: assert property (
    rise && (bit_cnt_ff == 5'h8 || (!addr_ff[0] &&
    (bit_cnt_ff == 5'd17 || bit_cnt_ff == 5'd26))) |-> !host_sda_oe)
    else $error("master drove an ack slot");
  a_read_host_quiet: assert property (
    rise && rd_dir && bit_cnt_ff > 5'h8 && bit_cnt_ff < 5'd26 && bit_cnt_ff != 5'd17
    |-> !host_sda_oe)
    else $error("master drove during read data");
  a_read_ack_slots: assert property (
    rise && rd_dir && bit_cnt_ff == 5'd17 |-> host_sda_oe && !dev_sda_oe)
    else $error("first read byte not acknowledged by master");
  a_read_last_nack: assert property (
    rise && rd_dir && bit_cnt_ff == 5'd26 |-> sda)
    else $error("last read byte not left unacknowledged");
  // the slave must not start pulling sda in the 8 cycles after a stop on the link
  a_stop_released: assert property (stop |=> !dev_sda_oe [*8])
    else $error("slave drove sda after stop");
  a_clock_follows: assert property (start |-> ##[1:1000] !scl)
    else $error("no clock after start");

  c_start: cover property (start);
  c_read_byte: cover property (rise && rd_dir && bit_cnt_ff == 5'd17);
  c_write_word: cover property (rise && !addr_ff[0] && acked_ff && bit_cnt_ff == 5'd26);
  c_foreign_addr: cover property (rise && bit_cnt_ff == 5'h8 && !dev_sda_oe);
endmodule

// ===== dv/serial_quad_mux_switch_control_tb.sv
// self-checking bench joining the mux switch master and slave
`timescale 1ns/1ps
module serial_quad_mux_switch_control_tb;
  import mux_ctl_pkg::*;
  localparam logic [2:0] PINS = 3'h5;
  logic        i_clk;
  logic        i_rst_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic [2:0]  pins;
  logic [7:0]  sw;
  logic        general_output;
  logic [31:0] rd;
  int          error_cnt;
  int          samples_checked;
  int          cyc;
  // command byte, expected switches, expected output; rows apply in order
  logic [16:0] rows [14] = '{{8'h80, 8'haa, 1'b0}, {8'h00, 8'h00, 1'b0},
    {8'h81, 8'h55, 1'b0}, {8'h0e, 8'h15, 1'b0}, {8'h8f, 8'h05, 1'b0},
    {8'h82, 8'h85, 1'b0}, {8'h0a, 8'h85, 1'b0}, {8'h9f, 8'h85, 1'b0},
    {8'h94, 8'h85, 1'b1}, {8'h90, 8'h81, 1'b1}, {8'h91, 8'h80, 1'b1},
    {8'h89, 8'h81, 1'b1}, {8'h1f, 8'h00, 1'b1}, {8'h14, 8'h00, 1'b0}};

  mux_link_if link ();

  mux_switch_master #(.QTR_CYC(6)) i_mux_switch_master (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_hsel      (hsel),
    .i_haddr     (haddr),
    .i_htrans    (htrans),
    .i_hwrite    (hwrite),
    .i_hsize     (3'h2),
    .i_hwdata    (hwdata),
    .i_hready    (hready),
    .o_hrdata    (hrdata),
    .o_hreadyout (hready),
    .o_hresp     (hresp),
    .link        (link)
  );

  mux_switch_slave i_mux_switch_slave (
    .i_clk            (i_clk),
    .i_rst_n          (i_rst_n),
    .i_address_select (pins),
    .o_switch         (sw),
    .o_general_output (general_output),
    .link             (link)
  );

  mux_link_asserts i_mux_link_asserts (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .scl         (link.scl),
    .host_sda_o  (link.host_sda_o),
    .host_sda_oe (link.host_sda_oe),
    .dev_sda_o   (link.dev_sda_o),
    .dev_sda_oe  (link.dev_sda_oe),
    .sda         (link.sda)
  );

  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // single AHB-Lite transfer; read data taken at the data-phase edge
  task automatic ahb(input logic wr, input logic [3:0] ofs, input logic [31:0] d);
    @(posedge i_clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {28'h0, ofs};
    do @(posedge i_clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge i_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  // one link transaction, then poll until the master is idle again
  task automatic xfer(input logic [15:0] w, input logic r, input logic [2:0] a);
    logic [31:0] d;
    d = 32'h0;
    d[15:0] = w;
    d[CMD_RD_POS] = r;
    d[CMD_ASEL_LSB +: 3] = a;
    ahb(1'b1, HOST_CMD_OFS, d);
    do ahb(1'b0, HOST_STAT_OFS, 32'h0); while (rd[STAT_BUSY_POS] !== 1'b0);
  endtask

  task automatic expect_state(input logic [7:0] s, input logic g);
    chk({24'h0, sw}, {24'h0, s});
    chk({31'h0, general_output}, {31'h0, g});
    xfer(16'h0, 1'b1, PINS);
    ahb(1'b0, HOST_RDATA_OFS, 32'h0);
    chk(rd, {16'h0, s, 4'h0, g, 3'h0});
  endtask

  initial begin
    i_rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    pins = PINS;
    error_cnt = 0;
    samples_checked = 0;
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    expect_state(8'h00, 1'b0);
    foreach (rows[i]) begin
      xfer({rows[i][16:9], 8'h03}, 1'b0, PINS);
      expect_state(rows[i][8:1], rows[i][0]);
    end
    for (int s = 2; s < 10; s++) begin
      xfer({1'b1, 7'(s), 8'h03}, 1'b0, PINS);
      chk({24'h0, sw}, {24'h0, 8'h80 >> (s - 2)});
      xfer({1'b0, 7'(s), 8'h03}, 1'b0, PINS);
      chk({24'h0, sw}, 32'h0);
    end
    // staged commands stay hidden until a commit; the later one per switch wins
    xfer({8'h81, 8'h01}, 1'b0, PINS);
    chk({24'h0, sw}, 32'h0);
    xfer({8'h01, 8'h01}, 1'b0, PINS);
    xfer({8'h80, 8'h03}, 1'b0, PINS);
    expect_state(8'haa, 1'b0);
    xfer({8'h94, 8'h03}, 1'b0, PINS);
    xfer({8'h81, 8'h02}, 1'b0, PINS);
    expect_state(8'h00, 1'b0);
    xfer({8'h80, 8'h03}, 1'b0, ~PINS);
    chk({31'h0, rd[STAT_NACK_POS]}, 32'h1);
    chk({24'h0, sw}, 32'h0);
    xfer({8'h94, 8'h03}, 1'b0, PINS);
    chk({31'h0, general_output}, 32'h1);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    chk({23'h0, sw, general_output}, 32'h0);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    chk({31'h0, hresp}, 32'h0);
    // the link must work again after a reset in mid-run
    expect_state(8'h00, 1'b0);
    conclude();
  end

  // around 60 link transactions of roughly 750 cycles each fit well inside
  initial cyc = 0;
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 80000) begin
      error_cnt++;
      conclude();
    end
  end
endmodule
